// >>> hw/sdm_map.vh
`ifndef SDM_MAP_VH
`define SDM_MAP_VH
// command codes as {chip_select_n, row, column, write strobes}
`define SDM_CMD_MRS 4'h0
`define SDM_CMD_REF 4'h1
`define SDM_CMD_PRE 4'h2
`define SDM_CMD_ACT 4'h3
`define SDM_CMD_WR 4'h4
`define SDM_CMD_RD 4'h5
`define SDM_CMD_BST 4'h6
`define SDM_CMD_NOP 4'h7
// address bus field positions
`define SDM_AP_BIT 10
`define SDM_COL_MSB 8
`define SDM_ROW_MSB 12
`define SDM_BL_MSB 2
`define SDM_BL_LSB 0
`define SDM_CL_MSB 6
`define SDM_CL_LSB 4
// mode configuration codes and reset value
`define SDM_BL_1 3'h0
`define SDM_BL_2 3'h1
`define SDM_BL_4 3'h2
`define SDM_BL_8 3'h3
`define SDM_BL_PAGE 3'h7
`define SDM_CL_3 3'h3
`define SDM_MODE_RST 13'h0020
// burst beats after the first, per length
`define SDM_LEFT_1 9'h000
`define SDM_LEFT_2 9'h001
`define SDM_LEFT_4 9'h003
`define SDM_LEFT_8 9'h007
`define SDM_LEFT_PAGE 9'h1ff
// storage and write queue shape
`define SDM_LANES 8
`define SDM_IDX_W 8
`define SDM_WQ_W 80
`define SDM_WQ_DEPTH 8
`define SDM_WQ_AW 3
// presence-detect storage
`define SDM_SPD_DEV 4'ha
`define SDM_SPD_DEPTH 256
`endif

// >>> hw/sdm_fifo.v
`timescale 1ns/10ps
module sdm_fifo #(
  parameter WIDTH = 80,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // honest full and empty from the fill count
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage write
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill count
  always @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // sdm_fifo

// >>> hw/sdm_cmd_port.v
`timescale 1ns/10ps
`include "sdm_map.vh"
module sdm_cmd_port (
  input wire ref_clk,
  input wire srst,
  input wire chip_select_n,
  input wire row_strobe_n,
  input wire col_strobe_n,
  input wire write_strobe_n,
  input wire clock_gate,
  input wire [1:0] bank_select,
  input wire [12:0] address_bus,
  input wire [7:0] byte_lane_mask,
  input wire [63:0] data_bus_in,
  output reg [63:0] data_bus_out,
  output reg [7:0] data_bus_oe,
  input wire spd_scl,
  input wire spd_sda_in,
  output wire spd_sda_out,
  output wire spd_sda_oe,
  input wire [2:0] spd_addr_sel,
  output wire [7:0] power_state,
  output wire [3:0] bank_open,
  output wire [12:0] mode_config,
  output wire write_overflow
);
  // one-hot memory states
  localparam ST_IDLE = 8'h01;
  localparam ST_ACTIVE = 8'h02;
  localparam ST_READ = 8'h04;
  localparam ST_WRITE = 8'h08;
  localparam ST_PD_PRE = 8'h10;
  localparam ST_PD_ACT = 8'h20;
  localparam ST_SELF_REF = 8'h40;
  localparam ST_SUSPEND = 8'h80;
  // one-hot presence-detect states
  localparam SP_IDLE = 6'h01;
  localparam SP_DEV = 6'h02;
  localparam SP_WADR = 6'h04;
  localparam SP_WDAT = 6'h08;
  localparam SP_RDAT = 6'h10;
  localparam SP_SKIP = 6'h20;

  // select high turns any strobe pattern into a no-op
  function [3:0] cmd_of;
    input cs_n;
    input ras_n;
    input cas_n;
    input we_n;
    begin
      cmd_of = cs_n ? `SDM_CMD_NOP : {1'b0, ras_n, cas_n, we_n};
    end
  endfunction

  // storage word index from bank, row and column
  function [7:0] mem_index;
    input [1:0] bank;
    input [12:0] row;
    input [8:0] col;
    begin
      mem_index = {bank, row[1:0], col[3:0]};
    end
  endfunction

  reg [7:0] state_r;
  reg [7:0] state_nxt;
  reg [3:0] bank_open_r;
  reg [3:0] bank_open_nxt;
  reg [12:0] open_row_r [0:3];
  reg [12:0] mode_r;
  reg [12:0] mode_nxt;
  reg [1:0] burst_bank_r;
  reg [1:0] burst_bank_nxt;
  reg [8:0] burst_col_r;
  reg [8:0] burst_col_nxt;
  reg [8:0] burst_left_r;
  reg [8:0] burst_left_nxt;
  reg burst_wr_r;
  reg burst_wr_nxt;
  reg burst_ap_r;
  reg burst_ap_nxt;
  reg burst_full_r;
  reg burst_full_nxt;
  reg burst_on;
  reg [8:0] len_left;
  reg overflow_r;
  reg [63:0] rd_a_r;
  reg [63:0] rd_b_r;
  reg rd_va_r;
  reg rd_vb_r;
  reg [7:0] mask_d1_r;
  wire [3:0] cmd;
  wire awake;
  wire take;
  wire in_burst;
  wire cmd_rw;
  wire cont;
  wire beat;
  wire beat_wr;
  wire [1:0] beat_bank;
  wire [8:0] beat_col;
  wire [7:0] beat_idx;
  wire cl3;
  wire [63:0] lane_q;
  wire wq_in_ready;
  wire wq_out_valid;
  wire [79:0] wq_out_data;
  wire drain;

  assign cmd = cmd_of(chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n);
  // commands are taken only while awake and the clock is live
  assign awake = |(state_r & (ST_IDLE | ST_ACTIVE | ST_READ | ST_WRITE));
  assign take = awake & clock_gate;
  assign in_burst = |(state_r & (ST_READ | ST_WRITE));
  assign cmd_rw = take & ((cmd == `SDM_CMD_RD) | (cmd == `SDM_CMD_WR)) & bank_open_r[bank_select];
  assign cont = take & in_burst & ~cmd_rw & (cmd != `SDM_CMD_BST);
  assign beat = cmd_rw | cont;
  assign beat_wr = cmd_rw ? (cmd == `SDM_CMD_WR) : burst_wr_r;
  assign beat_bank = cmd_rw ? bank_select : burst_bank_r;
  assign beat_col = cmd_rw ? address_bus[`SDM_COL_MSB:0] : burst_col_r;
  assign beat_idx = mem_index(beat_bank, open_row_r[beat_bank], beat_col);
  assign cl3 = (mode_r[`SDM_CL_MSB:`SDM_CL_LSB] == `SDM_CL_3);

  // beats left after the first, from the programmed length
  always @* begin
    case (mode_r[`SDM_BL_MSB:`SDM_BL_LSB])
      `SDM_BL_2: len_left = `SDM_LEFT_2;
      `SDM_BL_4: len_left = `SDM_LEFT_4;
      `SDM_BL_8: len_left = `SDM_LEFT_8;
      `SDM_BL_PAGE: len_left = `SDM_LEFT_PAGE;
      default: len_left = `SDM_LEFT_1;
    endcase
  end

  // command decode, bank bookkeeping and burst sequencing
  always @* begin
    bank_open_nxt = bank_open_r;
    mode_nxt = mode_r;
    burst_bank_nxt = burst_bank_r;
    burst_col_nxt = burst_col_r;
    burst_left_nxt = burst_left_r;
    burst_wr_nxt = burst_wr_r;
    burst_ap_nxt = burst_ap_r;
    burst_full_nxt = burst_full_r;
    burst_on = in_burst;
    if (take) begin
      case (cmd)
        `SDM_CMD_ACT: bank_open_nxt[bank_select] = 1'b1;
        `SDM_CMD_PRE: begin
          if (address_bus[`SDM_AP_BIT]) begin
            bank_open_nxt = 4'h0;
          end else begin
            bank_open_nxt[bank_select] = 1'b0;
          end
        end
        `SDM_CMD_MRS: begin
          if (state_r == ST_IDLE) begin
            mode_nxt = address_bus;
          end
        end
        `SDM_CMD_BST: burst_on = 1'b0;
        default: burst_on = burst_on;
      endcase
    end
    if (cmd_rw) begin
      burst_bank_nxt = bank_select;
      burst_col_nxt = address_bus[`SDM_COL_MSB:0] + 9'h001;
      burst_left_nxt = len_left;
      burst_wr_nxt = (cmd == `SDM_CMD_WR);
      burst_ap_nxt = address_bus[`SDM_AP_BIT];
      burst_full_nxt = (mode_r[`SDM_BL_MSB:`SDM_BL_LSB] == `SDM_BL_PAGE);
      burst_on = (len_left != `SDM_LEFT_1);
      if (!burst_on && address_bus[`SDM_AP_BIT]) begin
        bank_open_nxt[bank_select] = 1'b0;
      end
    end else if (cont) begin
      burst_col_nxt = burst_col_r + 9'h001;
      if (!burst_full_r) begin
        burst_left_nxt = burst_left_r - 9'h001;
        burst_on = (burst_left_r != 9'h001);
      end
      if (!burst_on && burst_ap_r) begin
        bank_open_nxt[burst_bank_r] = 1'b0;
      end
    end
  end

  // power and burst state selection
  always @* begin
    case (state_r)
      ST_IDLE, ST_ACTIVE, ST_READ, ST_WRITE: begin
        if (!clock_gate) begin
          if (in_burst) begin
            state_nxt = ST_SUSPEND;
          end else if (bank_open_r != 4'h0) begin
            state_nxt = ST_PD_ACT;
          end else if (cmd == `SDM_CMD_REF) begin
            state_nxt = ST_SELF_REF;
          end else begin
            state_nxt = ST_PD_PRE;
          end
        end else if (burst_on) begin
          state_nxt = burst_wr_nxt ? ST_WRITE : ST_READ;
        end else if (bank_open_nxt != 4'h0) begin
          state_nxt = ST_ACTIVE;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SUSPEND: state_nxt = clock_gate ? (burst_wr_r ? ST_WRITE : ST_READ) : ST_SUSPEND;
      // exit from power-down follows the raw pin level
      ST_PD_PRE: state_nxt = clock_gate ? ST_IDLE : ST_PD_PRE;
      ST_PD_ACT: state_nxt = clock_gate ? ST_ACTIVE : ST_PD_ACT;
      ST_SELF_REF: state_nxt = clock_gate ? ST_IDLE : ST_SELF_REF;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // control registers
  always @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      bank_open_r <= 4'h0;
      mode_r <= `SDM_MODE_RST;
      burst_bank_r <= 2'h0;
      burst_col_r <= 9'h000;
      burst_left_r <= 9'h000;
      burst_wr_r <= 1'b0;
      burst_ap_r <= 1'b0;
      burst_full_r <= 1'b0;
      overflow_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bank_open_r <= bank_open_nxt;
      mode_r <= mode_nxt;
      burst_bank_r <= burst_bank_nxt;
      burst_col_r <= burst_col_nxt;
      burst_left_r <= burst_left_nxt;
      burst_wr_r <= burst_wr_nxt;
      burst_ap_r <= burst_ap_nxt;
      burst_full_r <= burst_full_nxt;
      if (beat & beat_wr & ~wq_in_ready) begin
        overflow_r <= 1'b1;
      end
    end
  end

  // row captured with each activate
  always @(posedge ref_clk) begin
    if (take && cmd == `SDM_CMD_ACT) begin
      open_row_r[bank_select] <= address_bus[`SDM_ROW_MSB:0];
    end
  end

  // write beats queue up; drain yields to read fetches
  sdm_fifo #(
    .WIDTH(`SDM_WQ_W),
    .DEPTH(`SDM_WQ_DEPTH),
    .AW(`SDM_WQ_AW)
  ) u_wq (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(beat & beat_wr),
    .in_ready(wq_in_ready),
    .in_data({beat_idx, byte_lane_mask, data_bus_in}),
    .out_valid(wq_out_valid),
    .out_ready(~(beat & ~beat_wr)),
    .out_data(wq_out_data)
  );
  assign drain = wq_out_valid & ~(beat & ~beat_wr);

  // per-lane storage, masked lanes never written
  genvar ln;
  generate
    for (ln = 0; ln < `SDM_LANES; ln = ln + 1) begin : g_lane
      reg [7:0] lane_mem [0:255];
      always @(posedge ref_clk) begin
        if (drain && !wq_out_data[64 + ln]) begin
          lane_mem[wq_out_data[79:72]] <= wq_out_data[ln*8 +: 8];
        end
      end
      assign lane_q[ln*8 +: 8] = lane_mem[beat_idx];
    end
  endgenerate

  // read pipeline, held from the edge that enters suspend on
  always @(posedge ref_clk) begin
    if (srst) begin
      rd_a_r <= 64'h0;
      rd_b_r <= 64'h0;
      rd_va_r <= 1'b0;
      rd_vb_r <= 1'b0;
      mask_d1_r <= 8'h00;
      data_bus_out <= 64'h0;
      data_bus_oe <= 8'h00;
    end else if (state_r != ST_SUSPEND && !(in_burst && !clock_gate)) begin
      rd_a_r <= lane_q;
      rd_va_r <= beat & ~beat_wr;
      rd_b_r <= rd_a_r;
      rd_vb_r <= rd_va_r;
      mask_d1_r <= byte_lane_mask;
      data_bus_out <= cl3 ? rd_b_r : rd_a_r;
      data_bus_oe <= {8{cl3 ? rd_vb_r : rd_va_r}} & ~mask_d1_r;
    end
  end

  assign power_state = state_r;
  assign bank_open = bank_open_r;
  assign mode_config = mode_r;
  assign write_overflow = overflow_r;

  // presence-detect serial slave
  reg [2:0] scl_sy_r;
  reg [2:0] sda_sy_r;
  reg scl_r;
  reg sda_r;
  reg scl_q_r;
  reg sda_q_r;
  reg [5:0] sp_state_r;
  reg [3:0] sp_bit_r;
  reg [7:0] sp_sh_r;
  reg sp_ack_r;
  reg [7:0] sp_ptr_r;
  reg sp_oe_r;
  reg [7:0] spd_mem [0:`SDM_SPD_DEPTH-1];
  wire sp_start;
  wire sp_stop;
  wire sp_rise;
  wire sp_fall;

  // three-stage sync, level moves when last two agree
  always @(posedge ref_clk) begin
    if (srst) begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[1:0], spd_scl};
      sda_sy_r <= {sda_sy_r[1:0], spd_sda_in};
      if (scl_sy_r[2] == scl_sy_r[1]) begin
        scl_r <= scl_sy_r[2];
      end
      if (sda_sy_r[2] == sda_sy_r[1]) begin
        sda_r <= sda_sy_r[2];
      end
      scl_q_r <= scl_r;
      sda_q_r <= sda_r;
    end
  end

  // bus conditions timed by the master clock
  assign sp_start = scl_r & scl_q_r & sda_q_r & ~sda_r;
  assign sp_stop = scl_r & scl_q_r & ~sda_q_r & sda_r;
  assign sp_rise = scl_r & ~scl_q_r;
  assign sp_fall = ~scl_r & scl_q_r;

  // address, pointer, write and read byte handling
  always @(posedge ref_clk) begin
    if (srst) begin
      sp_state_r <= SP_IDLE;
      sp_bit_r <= 4'h0;
      sp_sh_r <= 8'h00;
      sp_ack_r <= 1'b0;
      sp_ptr_r <= 8'h00;
      sp_oe_r <= 1'b0;
    end else if (sp_start) begin
      sp_state_r <= SP_DEV;
      sp_bit_r <= 4'h0;
      sp_ack_r <= 1'b0;
      sp_oe_r <= 1'b0;
    end else if (sp_stop) begin
      sp_state_r <= SP_IDLE;
      sp_oe_r <= 1'b0;
    end else if (sp_rise) begin
      if (!sp_ack_r) begin
        sp_sh_r <= {sp_sh_r[6:0], sda_r};
        sp_bit_r <= sp_bit_r + 4'h1;
      end else if (sp_state_r == SP_RDAT && sda_r) begin
        sp_state_r <= SP_SKIP;
      end
    end else if (sp_fall) begin
      if (!sp_ack_r && sp_bit_r == 4'h8) begin
        sp_ack_r <= 1'b1;
        case (sp_state_r)
          SP_DEV: begin
            if (sp_sh_r[7:1] == {`SDM_SPD_DEV, spd_addr_sel}) begin
              sp_oe_r <= 1'b1;
              sp_state_r <= sp_sh_r[0] ? SP_RDAT : SP_WADR;
            end else begin
              sp_state_r <= SP_SKIP;
            end
          end
          SP_WADR: begin
            sp_ptr_r <= sp_sh_r;
            sp_oe_r <= 1'b1;
            sp_state_r <= SP_WDAT;
          end
          SP_WDAT: begin
            spd_mem[sp_ptr_r] <= sp_sh_r;
            sp_ptr_r <= sp_ptr_r + 8'h01;
            sp_oe_r <= 1'b1;
          end
          default: sp_oe_r <= 1'b0;
        endcase
      end else if (sp_ack_r) begin
        sp_ack_r <= 1'b0;
        sp_bit_r <= 4'h0;
        if (sp_state_r == SP_RDAT) begin
          sp_sh_r <= spd_mem[sp_ptr_r];
          sp_ptr_r <= sp_ptr_r + 8'h01;
          sp_oe_r <= ~spd_mem[sp_ptr_r][7];
        end else begin
          sp_oe_r <= 1'b0;
        end
      end else if (sp_state_r == SP_RDAT) begin
        sp_oe_r <= ~sp_sh_r[7];
      end
    end
  end

  // open-drain: only ever pulls low
  assign spd_sda_out = 1'b0;
  assign spd_sda_oe = sp_oe_r;
endmodule // sdm_cmd_port

// >>> tb/sdm_cmd_port_sva.sv
`timescale 1ns/10ps
`include "sdm_map.vh"
module sdm_cmd_port_chk (
  input wire ref_clk,
  input wire srst,
  input wire chip_select_n,
  input wire row_strobe_n,
  input wire col_strobe_n,
  input wire write_strobe_n,
  input wire clock_gate,
  input wire [1:0] bank_select,
  input wire [12:0] address_bus,
  input wire [7:0] byte_lane_mask,
  input wire [7:0] data_bus_oe,
  input wire spd_sda_out,
  input wire [7:0] power_state,
  input wire [3:0] bank_open,
  input wire [12:0] mode_config
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // pin command and state groups
  wire [3:0] cmd = {chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n};
  wire live = clock_gate && (power_state == 8'h01 || power_state == 8'h02);
  wire low = power_state == 8'h10 || power_state == 8'h20 || power_state == 8'h40;
  wire ap = address_bus[`SDM_AP_BIT];
  wire idle = power_state == 8'h01;
  property p_act;
    live && cmd == `SDM_CMD_ACT |=> bank_open[$past(bank_select)];
  endproperty
  a_act: assert property (p_act) else $error("bank not opened");
  property p_pre_one;
    live && cmd == `SDM_CMD_PRE && !ap |=> bank_open == ($past(bank_open) & ~(4'h1 << $past(bank_select)));
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("single precharge wrong");
  property p_pre_all;
    live && cmd == `SDM_CMD_PRE && ap |=> bank_open == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all wrong");
  property p_mrs;
    live && idle && cmd == `SDM_CMD_MRS |=> mode_config == $past(address_bus);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode not stored");
  property p_mrs_off;
    !idle && cmd == `SDM_CMD_MRS |=> $stable(mode_config);
  endproperty
  a_mrs_off: assert property (p_mrs_off) else $error("mode changed outside idle");
  property p_cs;
    idle && chip_select_n |=> bank_open == 4'h0 && $stable(mode_config);
  endproperty
  a_cs: assert property (p_cs) else $error("deselected command acted");
  property p_pd;
    idle && !clock_gate && cmd != `SDM_CMD_REF |=> power_state == 8'h10;
  endproperty
  a_pd: assert property (p_pd) else $error("no precharge power-down");
  property p_sr;
    idle && !clock_gate && cmd == `SDM_CMD_REF |=> power_state == 8'h40;
  endproperty
  a_sr: assert property (p_sr) else $error("no self refresh");
  property p_apd;
    power_state == 8'h02 && bank_open != 4'h0 && !clock_gate && cmd != `SDM_CMD_REF |=> power_state == 8'h20;
  endproperty
  a_apd: assert property (p_apd) else $error("no active power-down");
  property p_hold;
    low && !clock_gate |=> $stable(power_state) && $stable(bank_open) && $stable(mode_config);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved in low power");
  property p_exit;
    low && clock_gate |=> !low && $stable(bank_open);
  endproperty
  a_exit: assert property (p_exit) else $error("low power exit wrong");
  property p_mask;
    power_state != 8'h80 && $past(power_state) != 8'h80 |-> (data_bus_oe & $past(byte_lane_mask, 2)) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("masked lane driven");
  property p_sda;
    spd_sda_out == 1'b0;
  endproperty
  a_sda: assert property (p_sda) else $error("serial data driven high");
  // main scenarios reached
  c_sr: cover property (power_state == 8'h40);
  c_apd: cover property (power_state == 8'h20);
  c_mask: cover property (data_bus_oe == 8'h7f);
  c_susp: cover property (power_state == 8'h80);
endmodule // sdm_cmd_port_chk
bind sdm_cmd_port sdm_cmd_port_chk u_chk (
  .ref_clk(ref_clk), .srst(srst), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
  .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n), .clock_gate(clock_gate),
  .bank_select(bank_select), .address_bus(address_bus), .byte_lane_mask(byte_lane_mask),
  .data_bus_oe(data_bus_oe), .spd_sda_out(spd_sda_out), .power_state(power_state),
  .bank_open(bank_open), .mode_config(mode_config));

// >>> tb/sdm_ctl_model.sv
`timescale 1ns/10ps
`include "sdm_map.vh"
module sdm_ctl_model (
  input wire ref_clk,
  input wire spd_sda_oe,
  output reg chip_select_n,
  output reg row_strobe_n,
  output reg col_strobe_n,
  output reg write_strobe_n,
  output reg clock_gate,
  output reg [1:0] bank_select,
  output reg [12:0] address_bus,
  output reg [7:0] byte_lane_mask,
  output reg [63:0] data_bus_in,
  output reg spd_scl,
  output wire spd_sda_in
);
  reg sda_low_r;
  // pulled-up line, low while either side pulls it
  assign spd_sda_in = ~(spd_sda_oe | sda_low_r);
  // deselected and idle from time zero
  initial begin
    {chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'hf;
    clock_gate = 1'b1;
    bank_select = 2'h0;
    address_bus = 13'h0000;
    byte_lane_mask = 8'h00;
    data_bus_in = 64'h0;
    spd_scl = 1'b1;
    sda_low_r = 1'b0;
  end
  // one command per edge, held until the taking edge
  task cmd(input [3:0] k, input [1:0] b, input [12:0] a, input [7:0] m, input [63:0] d);
    {chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = k;
    bank_select = b;
    address_bus = a;
    byte_lane_mask = m;
    data_bus_in = d;
    @(posedge ref_clk);
    #1;
  endtask
  // clock gate pin, changed only here
  task gate(input g);
    clock_gate = g;
  endtask
  task wt(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // start or repeated start: data falls while clock high
  task spd_start;
    sda_low_r = 1'b0;
    wt(8);
    spd_scl = 1'b1;
    wt(8);
    sda_low_r = 1'b1;
    wt(8);
    spd_scl = 1'b0;
    wt(3);
  endtask
  task spd_stop;
    sda_low_r = 1'b1;
    wt(8);
    spd_scl = 1'b1;
    wt(8);
    sda_low_r = 1'b0;
    wt(8);
  endtask
  // eight bits msb first then acknowledge, line sampled at clock high
  task spd_byte(input [8:0] tx, output [8:0] rx);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      sda_low_r = ~tx[i];
      wt(8);
      spd_scl = 1'b1;
      wt(10);
      rx[i] = spd_sda_in;
      spd_scl = 1'b0;
      wt(3);
    end
  endtask
endmodule // sdm_ctl_model

// >>> tb/sdram_module_command_port_tb.sv
`timescale 1ns/10ps
`include "sdm_map.vh"
module sdram_module_command_port_tb;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg [2:0] spd_addr_sel = 3'h5;
  integer err_total = 0;
  integer n_tests = 0;
  wire chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n, clock_gate;
  wire spd_scl, spd_sda_in, spd_sda_out, spd_sda_oe, write_overflow;
  wire [1:0] bank_select;
  wire [12:0] address_bus;
  wire [7:0] byte_lane_mask;
  wire [63:0] data_bus_in;
  wire [63:0] data_bus_out;
  wire [7:0] data_bus_oe;
  wire [7:0] power_state;
  wire [3:0] bank_open;
  wire [12:0] mode_config;
  // 10 MHz system clock
  always #50 ref_clk = ~ref_clk;
  sdm_cmd_port uut (
    .ref_clk(ref_clk), .srst(srst), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n), .clock_gate(clock_gate),
    .bank_select(bank_select), .address_bus(address_bus), .byte_lane_mask(byte_lane_mask),
    .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .spd_scl(spd_scl), .spd_sda_in(spd_sda_in), .spd_sda_out(spd_sda_out), .spd_sda_oe(spd_sda_oe),
    .spd_addr_sel(spd_addr_sel), .power_state(power_state), .bank_open(bank_open),
    .mode_config(mode_config), .write_overflow(write_overflow));
  sdm_ctl_model ctl (
    .ref_clk(ref_clk), .spd_sda_oe(spd_sda_oe), .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n),
    .clock_gate(clock_gate), .bank_select(bank_select), .address_bus(address_bus),
    .byte_lane_mask(byte_lane_mask), .data_bus_in(data_bus_in), .spd_scl(spd_scl),
    .spd_sda_in(spd_sda_in));
  task chk(input [63:0] got, input [63:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // command without data, released data lines toggle
  task c(input [3:0] k, input [1:0] b, input [12:0] a);
    ctl.cmd(k, b, a, 8'h00, ~data_bus_in);
  endtask
  task nops(input integer n);
    repeat (n) c(`SDM_CMD_NOP, 2'h0, 13'h0000);
  endtask
  task t_reset;
    chk(power_state, 8'h01);
    chk(bank_open, 4'h0);
    chk(mode_config, `SDM_MODE_RST);
    chk({data_bus_oe, spd_sda_oe, write_overflow}, 10'h000);
  endtask
  // 100 us of no-ops, precharge all, then burst of four with latency two
  task t_init;
    nops(1000);
    c(`SDM_CMD_PRE, 2'h0, 13'h0400);
    c(`SDM_CMD_MRS, 2'h0, 13'h0022);
    chk(mode_config, 13'h0022);
    c(4'h8 | `SDM_CMD_ACT, 2'h2, 13'h0000);
    chk(bank_open, 4'h0);
  endtask
  task t_banks;
    c(`SDM_CMD_ACT, 2'h0, 13'h0000);
    chk(bank_open, 4'h1);
    c(`SDM_CMD_ACT, 2'h1, 13'h1fff);
    chk(bank_open, 4'h3);
    c(4'h8 | `SDM_CMD_ACT, 2'h2, 13'h0000);
    chk(bank_open, 4'h3);
    c(`SDM_CMD_MRS, 2'h0, 13'h0011);
    chk(mode_config, 13'h0022);
    c(`SDM_CMD_PRE, 2'h1, 13'h0000);
    chk(bank_open, 4'h1);
    c(`SDM_CMD_ACT, 2'h2, 13'h0000);
    c(`SDM_CMD_PRE, 2'h0, 13'h0400);
    chk(bank_open, 4'h0);
    c(`SDM_CMD_ACT, 2'h0, 13'h0000);
    chk(power_state, 8'h02);
  endtask
  // write burst of four to columns 0..3, lane mask on second beat
  task wr4(input [7:0] base, input [7:0] m1);
    integer i;
    ctl.cmd(`SDM_CMD_WR, 2'h0, 13'h0000, 8'h00, {8{base}});
    for (i = 1; i < 4; i = i + 1) begin
      ctl.cmd(`SDM_CMD_NOP, 2'h0, 13'h0000, (i == 1) ? m1 : 8'h00, {8{base + i[7:0]}});
    end
    nops(8);
  endtask
  task t_wr_rd;
    integer i;
    reg [63:0] e;
    wr4(8'h10, 8'h00);
    wr4(8'hc0, 8'h0f);
    c(`SDM_CMD_RD, 2'h0, 13'h0400);
    for (i = 0; i < 4; i = i + 1) begin
      ctl.cmd(`SDM_CMD_NOP, 2'h0, 13'h0000, (i == 0) ? 8'h80 : 8'h00, ~data_bus_in);
      e = {8{8'hc0 + i[7:0]}};
      if (i == 1) begin
        e[31:0] = {4{8'h11}};
      end
      chk(data_bus_out[55:0], e[55:0]);
      chk(data_bus_oe, (i == 1) ? 8'h7f : 8'hff);
    end
    nops(1);
    chk(data_bus_oe, 8'h00);
    chk({bank_open, write_overflow}, 5'h00);
  endtask
  // low-power entry and exit from bank status
  task t_power;
    chk(power_state, 8'h01);
    ctl.gate(1'b0);
    nops(1);
    chk(power_state, 8'h10);
    c(`SDM_CMD_ACT, 2'h3, 13'h0000);
    chk(bank_open, 4'h0);
    ctl.gate(1'b1);
    nops(1);
    chk(power_state, 8'h01);
    c(`SDM_CMD_ACT, 2'h0, 13'h0000);
    ctl.gate(1'b0);
    nops(1);
    chk(power_state, 8'h20);
    ctl.gate(1'b1);
    nops(1);
    c(`SDM_CMD_PRE, 2'h0, 13'h0400);
    ctl.gate(1'b0);
    c(`SDM_CMD_REF, 2'h0, 13'h0000);
    chk(power_state, 8'h40);
    ctl.gate(1'b1);
    nops(1);
    chk(power_state, 8'h01);
  endtask
  // latency three, full page, suspend mid burst, then terminate
  task t_burst;
    c(`SDM_CMD_MRS, 2'h0, 13'h0037);
    c(`SDM_CMD_ACT, 2'h0, 13'h0000);
    c(`SDM_CMD_RD, 2'h0, 13'h0000);
    nops(2);
    chk(data_bus_out, {8{8'hc0}});
    chk(data_bus_oe, 8'hff);
    ctl.gate(1'b0);
    nops(3);
    chk(power_state, 8'h80);
    chk(data_bus_out, {8{8'hc0}});
    ctl.gate(1'b1);
    nops(2);
    chk(data_bus_out, {{4{8'hc1}}, {4{8'h11}}});
    c(`SDM_CMD_BST, 2'h0, 13'h0000);
    nops(3);
    chk(power_state, 8'h02);
    chk(data_bus_oe, 8'h00);
  endtask
  task t_spd;
    reg [8:0] r;
    ctl.spd_start;
    ctl.spd_byte({4'hb, spd_addr_sel, 2'b01}, r);
    chk(r[0], 1'b1);
    ctl.spd_stop;
    ctl.spd_start;
    ctl.spd_byte({`SDM_SPD_DEV, spd_addr_sel, 2'b01}, r);
    chk(r[0], 1'b0);
    ctl.spd_byte({8'h10, 1'b1}, r);
    ctl.spd_byte({8'h3c, 1'b1}, r);
    chk(r[0], 1'b0);
    ctl.spd_stop;
    ctl.spd_start;
    ctl.spd_byte({`SDM_SPD_DEV, spd_addr_sel, 2'b01}, r);
    ctl.spd_byte({8'h10, 1'b1}, r);
    ctl.spd_start;
    ctl.spd_byte({`SDM_SPD_DEV, spd_addr_sel, 2'b11}, r);
    ctl.spd_byte(9'h1ff, r);
    chk(r[8:1], 8'h3c);
    ctl.spd_stop;
  endtask
  // reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    nops(1);
    t_reset;
    t_init;
    t_banks;
    t_wr_rd;
    t_power;
    t_burst;
    t_spd;
    end_sim;
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total = err_total + 1;
    end_sim;
  end
endmodule // sdram_module_command_port_tb
